// file: rtl/fsc_regs.vh
// Purpose: Constants for the front-side bus sideband control block.
// Assumes: 32-bit classic Wishbone register access, word aligned.
// Notes: Offsets are byte addresses.
`ifndef FSC_REGS_VH
`define FSC_REGS_VH
`define FSC_OFF_CTRL 8'h00
`define FSC_OFF_STAT 8'h04
`define FSC_OFF_LOCK 8'h08
`define FSC_OFF_ERR 8'h0c
// Control register fields
`define FSC_CTRL_NE_BIT 0
`define FSC_CTRL_LIC_DIS_BIT 1
`define FSC_CTRL_STALL_BIT 2
`define FSC_CTRL_RESET 32'h00000000
// Lock register fields
`define FSC_LOCK_REQ_BIT 0
`define FSC_LOCK_LAST_BIT 1
// Error register fields
`define FSC_ERR_RAISE_BIT 0
`define FSC_ERR_FPERR_BIT 1
`define FSC_ERR_FPCLR_BIT 2
// Status register fields
`define FSC_ST_INTERNAL_ERROR_N_BIT 0
`define FSC_ST_SHUT_BIT 1
`define FSC_ST_IGN_BIT 2
`define FSC_ST_FPEXC_BIT 3
`define FSC_ST_INIT_BIT 4
`define FSC_ST_BUILTIN_SELF_TEST_BIT 5
`define FSC_ST_MIRQ_BIT 6
`define FSC_ST_NMI_BIT 7
`define FSC_ST_LOCAL_IRQ_IN_ZERO_BIT 8
`define FSC_ST_LOCAL_IRQ_IN_ONE_BIT 9
`define FSC_ST_LOCK_BIT 10
`define FSC_ST_SNPSTL_BIT 11
`define FSC_ST_PRIO_BIT 12
`endif

// file: rtl/fsc_sideband.v
// Purpose: Sideband control of a front-side bus agent: snoop stall, internal
//   error hold, numeric-error ignore, warm init, self-test select, local irqs, lock.
// Assumes: Sideband pins named _n are active low; single 125 MHz clock; Wishbone slave.
// Notes: Software stands in for the core; registers model the core's view.
`timescale 1ns/100ps
`include "fsc_regs.vh"
module fsc_sideband #(
  parameter RESET_VECTOR = 32'hfffffff0
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire [31:0] wb_adr_in,
  input wire [31:0] wb_dat_in,
  input wire [3:0] wb_sel_in,
  input wire wb_we_in,
  input wire wb_cyc_in,
  input wire wb_stb_in,
  output wire [31:0] wb_dat_out,
  output wire wb_ack_out,
  input wire snoop_hit_n_in,
  output wire snoop_hit_n_out,
  output wire snoop_hit_n_oe_out,
  input wire snoop_modified_n_in,
  output wire snoop_modified_n_out,
  output wire snoop_modified_n_oe_out,
  input wire snoop_req_in,
  output wire snoop_resp_out,
  output wire internal_error_n_out,
  output wire shutdown_out,
  input wire bus_initialise_n_in,
  input wire ignore_numeric_error_n_in,
  input wire warm_init_n_in,
  input wire [1:0] local_irq_in,
  output wire maskable_irq_request_out,
  output wire nmi_out,
  output wire [1:0] local_irq_event_out,
  input wire bus_lock_n_in,
  output wire bus_lock_n_out,
  output wire bus_lock_n_oe_out,
  input wire priority_request_n_in,
  input wire txn_end_in,
  output wire [31:0] exec_addr_out,
  output wire int_state_clear_out,
  output wire builtin_self_test_out
);
  // Lock sequencer states
  localparam LK_IDLE = 2'b00;
  localparam LK_HELD = 2'b01;
  localparam LK_LAST = 2'b10;

  function [31:0] fsc_mask;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] sel;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1)
      begin
        fsc_mask[k*8 +: 8] = sel[k] ? new_val[k*8 +: 8] : old_val[k*8 +: 8];
      end
    end
  endfunction

  reg ack_r;
  reg [31:0] rdat_r;
  reg [31:0] ctrl_r;
  reg internal_error_n_r;
  reg shut_r;
  reg fperr_r;
  reg fpexc_r;
  reg builtin_self_test_r;
  reg init_seen_r;
  reg [31:0] exec_r;
  reg intclr_r;
  reg [1:0] irq_s1_r;
  reg [1:0] irq_s2_r;
  reg [1:0] irq_s3_r;
  reg [1:0] irq_ev_r;
  reg [1:0] lk_state_r;
  reg [1:0] lk_state_nxt;
  reg snoop_resp_r;
  reg stall_r;
  reg rst_seen_r;

  wire wb_hit = wb_cyc_in & wb_stb_in & ~ack_r;
  wire wr = wb_hit & wb_we_in;
  wire [7:0] off = wb_adr_in[7:0];
  wire wr_ctrl = wr & (off == `FSC_OFF_CTRL);
  wire wr_lock = wr & (off == `FSC_OFF_LOCK) & wb_sel_in[0];
  wire wr_err = wr & (off == `FSC_OFF_ERR) & wb_sel_in[0];
  wire native_err = ctrl_r[`FSC_CTRL_NE_BIT];
  wire lic_dis = ctrl_r[`FSC_CTRL_LIC_DIS_BIT];
  wire warm_init = ~warm_init_n_in;
  wire internal_error_n_clear = ~bus_initialise_n_in | warm_init;
  // Ignore only has force while native reporting is off
  wire ignoring = ~ignore_numeric_error_n_in & ~native_err;
  wire [31:0] status;

  assign wb_ack_out = ack_r;
  assign wb_dat_out = rdat_r;

  // Read data is latched with ack; unmapped offsets read zero and writes are dropped
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ack_r <= 1'b0;
      rdat_r <= 32'h00000000;
    end
    else
    begin
      ack_r <= wb_hit;
      case (off)
        `FSC_OFF_CTRL: rdat_r <= ctrl_r;
        `FSC_OFF_STAT: rdat_r <= status;
        `FSC_OFF_LOCK: rdat_r <= {30'h00000000, (lk_state_r == LK_LAST), (lk_state_r != LK_IDLE)};
        default: rdat_r <= 32'h00000000;
      endcase
    end
  end

  // Controller disable bit resets to zero so the local irq roles are the default
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      ctrl_r <= `FSC_CTRL_RESET;
    else if (wr_ctrl)
      ctrl_r <= fsc_mask(ctrl_r, wb_dat_in, wb_sel_in) & 32'h00000007;
  end

  // Internal error: set wins over clear so no raise is lost
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      internal_error_n_r <= 1'b0;
      shut_r <= 1'b0;
    end
    else
    begin
      shut_r <= wr_err & wb_dat_in[`FSC_ERR_RAISE_BIT] & ~internal_error_n_r;
      if (wr_err & wb_dat_in[`FSC_ERR_RAISE_BIT])
        internal_error_n_r <= 1'b1;
      else if (internal_error_n_clear)
        internal_error_n_r <= 1'b0;
    end
  end
  assign internal_error_n_out = ~internal_error_n_r;
  assign shutdown_out = shut_r;

  // Pending numeric error and the exception it causes
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fperr_r <= 1'b0;
      fpexc_r <= 1'b0;
    end
    else
    begin
      if (wr_err & wb_dat_in[`FSC_ERR_FPERR_BIT])
        fperr_r <= 1'b1;
      else if (wr_err & wb_dat_in[`FSC_ERR_FPCLR_BIT])
        fperr_r <= 1'b0;
      // Floating-point state survives warm init, so fperr_r is not cleared there
      if (fperr_r & ~ignoring)
        fpexc_r <= 1'b1;
      else if (ignoring | (wr_err & wb_dat_in[`FSC_ERR_FPCLR_BIT]))
        fpexc_r <= 1'b0;
    end
  end

  // Warm init: integer state clear, restart at reset vector, self-test capture
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      exec_r <= 32'h00000000;
      intclr_r <= 1'b0;
      init_seen_r <= 1'b0;
      builtin_self_test_r <= 1'b0;
      rst_seen_r <= 1'b0;
    end
    else
    begin
      rst_seen_r <= 1'b1;
      // First clocked edge after release samples warm init as a strap
      if (!rst_seen_r)
        builtin_self_test_r <= warm_init;
      else
        builtin_self_test_r <= 1'b0;
      init_seen_r <= warm_init;
      intclr_r <= warm_init;
      if (!rst_seen_r | (init_seen_r & ~warm_init))
        exec_r <= RESET_VECTOR;
    end
  end
  assign exec_addr_out = exec_r;
  assign int_state_clear_out = intclr_r;
  assign builtin_self_test_out = builtin_self_test_r;

  // Local irq synchroniser; levels come from the second stage, events from the second and third
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      irq_s1_r <= 2'b00;
      irq_s2_r <= 2'b00;
      irq_s3_r <= 2'b00;
      irq_ev_r <= 2'b00;
    end
    else
    begin
      irq_s1_r <= local_irq_in;
      irq_s2_r <= irq_s1_r;
      irq_s3_r <= irq_s2_r;
      irq_ev_r <= lic_dis ? 2'b00 : (irq_s2_r & ~irq_s3_r);
    end
  end
  assign maskable_irq_request_out = lic_dis & irq_s2_r[0];
  assign nmi_out = lic_dis & irq_s2_r[1];
  assign local_irq_event_out = irq_ev_r;

  // Snoop answers are never gated by warm init
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      snoop_resp_r <= 1'b0;
      stall_r <= 1'b0;
    end
    else
    begin
      snoop_resp_r <= snoop_req_in;
      stall_r <= snoop_req_in & ctrl_r[`FSC_CTRL_STALL_BIT];
    end
  end
  assign snoop_resp_out = snoop_resp_r;
  // Stall drives both lines low in the same cycle, each cycle it is held
  assign snoop_hit_n_out = ~stall_r;
  assign snoop_modified_n_out = ~stall_r;
  assign snoop_hit_n_oe_out = stall_r;
  assign snoop_modified_n_oe_out = stall_r;

  // Lock sequencer: held from first start until the last transaction ends
  always @*
  begin
    lk_state_nxt = lk_state_r;
    case (lk_state_r)
      LK_IDLE:
      begin
        if (wr_lock & wb_dat_in[`FSC_LOCK_REQ_BIT])
          lk_state_nxt = wb_dat_in[`FSC_LOCK_LAST_BIT] ? LK_LAST : LK_HELD;
      end
      LK_HELD:
      begin
        if (wr_lock & wb_dat_in[`FSC_LOCK_LAST_BIT])
          lk_state_nxt = LK_LAST;
      end
      LK_LAST:
      begin
        if (txn_end_in)
          lk_state_nxt = LK_IDLE;
      end
      default: lk_state_nxt = LK_IDLE;
    endcase
  end

  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      lk_state_r <= LK_IDLE;
    else
      lk_state_r <= lk_state_nxt;
  end
  assign bus_lock_n_out = ~(lk_state_r != LK_IDLE);
  assign bus_lock_n_oe_out = (lk_state_r != LK_IDLE);

  assign status = {19'h00000,
    ~priority_request_n_in & ~bus_lock_n_in,
    ~snoop_hit_n_in & ~snoop_modified_n_in,
    ~bus_lock_n_in,
    irq_s2_r,
    nmi_out,
    maskable_irq_request_out,
    builtin_self_test_r,
    warm_init,
    fpexc_r,
    ignoring,
    shut_r,
    internal_error_n_r};
endmodule

// file: tb/fsc_props.sv
// Purpose: Checker on the sideband block ports
// Assumes: One clock, async active-low reset
// Notes: Pin-level stall and lock relations are watched at the outputs
`timescale 1ns/100ps
module fsc_props (
  input wire clk_in,
  input wire rst_n_in,
  input wire snoop_hit_n_out,
  input wire snoop_hit_n_oe_out,
  input wire snoop_modified_n_out,
  input wire snoop_modified_n_oe_out,
  input wire snoop_req_in,
  input wire snoop_resp_out,
  input wire internal_error_n_out,
  input wire shutdown_out,
  input wire bus_initialise_n_in,
  input wire warm_init_n_in,
  input wire [1:0] local_irq_in,
  input wire maskable_irq_request_out,
  input wire bus_lock_n_oe_out,
  input wire txn_end_in,
  input wire int_state_clear_out,
  input wire builtin_self_test_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_warm2; !warm_init_n_in [*2]; endsequence
  property p_stall;
    snoop_hit_n_oe_out |-> snoop_modified_n_oe_out && !snoop_hit_n_out && !snoop_modified_n_out;
  endproperty
  a_stall: assert property (p_stall) else $error("stall lines apart");
  property p_internal_error_n;
    !internal_error_n_out && bus_initialise_n_in && warm_init_n_in |=> !internal_error_n_out;
  endproperty
  a_internal_error_n: assert property (p_internal_error_n) else $error("error dropped");
  property p_shut; shutdown_out |-> $fell(internal_error_n_out); endproperty
  a_shut: assert property (p_shut) else $error("stray shutdown");
  property p_snp; snoop_req_in && !warm_init_n_in |=> snoop_resp_out; endproperty
  a_snp: assert property (p_snp) else $error("snoop lost");
  property p_irq; maskable_irq_request_out |-> $past(local_irq_in[0], 2); endproperty
  a_irq: assert property (p_irq) else $error("irq unsynced");
  property p_lock; $fell(bus_lock_n_oe_out) |-> $past(txn_end_in); endproperty
  a_lock: assert property (p_lock) else $error("lock early");
  property p_builtin_self_test;
    builtin_self_test_out |-> $past(warm_init_n_in) == 1'h0 ##1 !builtin_self_test_out;
  endproperty
  a_builtin_self_test: assert property (p_builtin_self_test) else $error("bad self-test");
  property p_int; s_warm2 |-> int_state_clear_out; endproperty
  a_int: assert property (p_int) else $error("no clear");
endmodule

// file: tb/fsc_prio_agent.sv
// Purpose: Priority bus agent of the core logic
// Assumes: Lock pin pulled up when released
// Notes: Takes the bus only once lock is seen high
`timescale 1ns/100ps
module fsc_prio_agent (
  input wire clk_in,
  input wire rst_n_in,
  input wire want_in,
  input wire bus_lock_n_in,
  output logic priority_request_n_out,
  output logic owns_out
);
  always @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      priority_request_n_out <= 1'h1;
      owns_out <= 1'h0;
    end
    else
    begin
      priority_request_n_out <= !want_in;
      owns_out <= want_in && !priority_request_n_out && bus_lock_n_in;
    end
endmodule

// file: tb/testbench.sv
// Purpose: Self-checking bench for the sideband block
// Assumes: Released pins read high
// Notes: Async inputs change on clock edges only, so they stay valid around any handshake
`timescale 1ns/100ps
module testbench;
  localparam logic [31:0] VEC = 32'h00001234;
  logic clk, rst_n, cyc, stb, we, sreq, bus_initialise_n_n, ign_n, warm_n, tend, want, ack, sresp, internal_error_n_n;
  logic hit_o, hit_oe, mod_o, mod_oe, shut, mirq, nmi, lock_o, lock_oe, prio_n, own, clr, builtin_self_test;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q, exec;
  logic [1:0] irq, ev, v;
  int checks, mismatches, nshut, nbist, nev, ne, ig, dis;
  wire hit_p = hit_oe ? hit_o : 1'h1;
  wire mod_p = mod_oe ? mod_o : 1'h1;
  wire lock_p = lock_oe ? lock_o : 1'h1;
  fsc_sideband #(.RESET_VECTOR(VEC)) DUT (.clk_in(clk), .rst_n_in(rst_n),
    .wb_adr_in({24'h0, adr}), .wb_dat_in(wdat), .wb_sel_in(4'hf), .wb_we_in(we),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_dat_out(rdat), .wb_ack_out(ack),
    .snoop_hit_n_in(hit_p), .snoop_hit_n_out(hit_o), .snoop_hit_n_oe_out(hit_oe),
    .snoop_modified_n_in(mod_p), .snoop_modified_n_out(mod_o),
    .snoop_modified_n_oe_out(mod_oe), .snoop_req_in(sreq), .snoop_resp_out(sresp),
    .internal_error_n_out(internal_error_n_n), .shutdown_out(shut), .bus_initialise_n_in(bus_initialise_n_n),
    .ignore_numeric_error_n_in(ign_n), .warm_init_n_in(warm_n), .local_irq_in(irq),
    .maskable_irq_request_out(mirq), .nmi_out(nmi), .local_irq_event_out(ev),
    .bus_lock_n_in(lock_p), .bus_lock_n_out(lock_o), .bus_lock_n_oe_out(lock_oe),
    .priority_request_n_in(prio_n), .txn_end_in(tend), .exec_addr_out(exec),
    .int_state_clear_out(clr), .builtin_self_test_out(builtin_self_test));
  fsc_prio_agent PA (.clk_in(clk), .rst_n_in(rst_n), .want_in(want), .bus_lock_n_in(lock_p),
    .priority_request_n_out(prio_n), .owns_out(own));
  always @(posedge clk)
  begin
    nshut <= nshut + (shut === 1'h1);
    nbist <= nbist + (builtin_self_test === 1'h1);
    nev <= nev + (ev[0] === 1'h1);
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'h1 && n < 40);
    if (n >= 40)
    begin
      chk("ack", 1, 0);
      tally_and_finish;
    end
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask
  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    {rst_n, cyc, stb, we, sreq, tend, want, adr, wdat, irq} = '0;
    {bus_initialise_n_n, ign_n, warm_n} = 3'h7;
    {checks, mismatches, nshut, nbist, nev} = '0;
    void'($urandom(32'h77ed8def));
    tk(2);
    rst_n <= 1'h1;
    tk(2);
    chk("vec", VEC, exec);
    wb(0, 8'h00, 0);
    chk("ctrl", 0, q);
    wb(0, 8'h10, 0);
    chk("unmapped", 0, q);
    wb(1, 8'h00, 4);
    sreq <= 1'h1;
    tk(3);
    chk("stall", 0, {hit_p, mod_p});
    wb(0, 8'h04, 0);
    chk("stall_st", 32'h800, q & 32'h800);
    sreq <= 1'h0;
    tk(2);
    chk("idle", 3, {hit_p, mod_p});
    wb(1, 8'h0c, 1);
    tk(5);
    chk("internal_error_n", 0, internal_error_n_n);
    chk("shut", 1, nshut);
    bus_initialise_n_n <= 1'h0;
    tk(1);
    bus_initialise_n_n <= 1'h1;
    tk(2);
    chk("internal_error_n_clr", 1, internal_error_n_n);
    for (int i = 0; i < 4; i++)
    begin
      ne = i % 2;
      ig = i / 2;
      wb(1, 8'h00, ne);
      ign_n <= !ig;
      wb(1, 8'h0c, 2);
      wb(0, 8'h04, 0);
      chk("fp", {!(ig && !ne), ig && !ne} << 2, q & 32'hc);
      wb(1, 8'h0c, 4);
    end
    ign_n <= 1'h1;
    for (int i = 0; i < 8; i++)
    begin
      dis = $urandom % 2;
      v = $urandom % 4;
      wb(1, 8'h00, dis << 1);
      irq <= v;
      tk(4);
      chk("irq", dis ? v : 0, {nmi, mirq});
    end
    // Controller enabled again: one rising irq gives exactly one event pulse
    wb(1, 8'h00, 0);
    irq <= 2'h0;
    tk(4);
    ne = nev;
    irq <= 2'h1;
    tk(6);
    chk("irq_ev", 1, nev - ne);
    irq <= 2'h0;
    wb(1, 8'h08, 1);
    chk("lock", 2, {lock_oe, lock_p});
    want <= 1'h1;
    tend <= 1'h1;
    tk(1);
    tend <= 1'h0;
    tk(3);
    chk("held", 2, {lock_oe, lock_p});
    chk("own", 0, own);
    wb(1, 8'h08, 2);
    tend <= 1'h1;
    tk(1);
    tend <= 1'h0;
    tk(3);
    chk("unlock", 1, {lock_oe, lock_p});
    chk("own2", 1, own);
    want <= 1'h0;
    wb(1, 8'h0c, 1);
    sreq <= 1'h1;
    warm_n <= 1'h0;
    tk(3);
    chk("clr", 1, clr);
    chk("snoop", 1, sresp);
    chk("internal_error_n_w", 1, internal_error_n_n);
    warm_n <= 1'h1;
    sreq <= 1'h0;
    tk(3);
    chk("vec_w", VEC, exec);
    chk("clr_end", 0, clr);
    chk("nobist", 0, nbist);
    warm_n <= 1'h0;
    rst_n <= 1'h0;
    tk(2);
    rst_n <= 1'h1;
    tk(2);
    warm_n <= 1'h1;
    tk(1);
    chk("builtin_self_test", 1, nbist);
    tally_and_finish;
  end
endmodule
bind fsc_sideband fsc_props u_props (.clk_in, .rst_n_in, .snoop_hit_n_out,
  .snoop_hit_n_oe_out, .snoop_modified_n_out, .snoop_modified_n_oe_out, .snoop_req_in,
  .snoop_resp_out, .internal_error_n_out, .shutdown_out, .bus_initialise_n_in,
  .warm_init_n_in, .local_irq_in, .maskable_irq_request_out, .bus_lock_n_oe_out,
  .txn_end_in, .int_state_clear_out, .builtin_self_test_out);
